// file: src/adc_seq_ctrl.sv
/*
  Sequencing control of an 8-bit four-channel successive-approximation
  converter: channel select, prescaler, single and continuous runs,
  completion flag or interrupt request, result register, wait and stop.
  Assumes an AXI4-Lite master on CORE_CLK_I, an analog core that delivers
  its 8-bit result on ANALOG_RESULT_I as bit stream finished, and CPU
  mode levels STOP_MODE_I and WAIT_MODE_I that come from outside this domain.
*/
// Local design decisions: register access over AXI4-Lite and the register offsets.
module adc_seq_ctrl #(
  parameter int CONV_LEN = adc_seq_pkg::CONV_CYCLES
) (
  input  wire logic                      CORE_CLK_I,
  input  wire logic                      RST_I,
  input  wire logic                      CLK_EN_I,
  input  wire logic [3:0]                S_AXI_AWADDR_I,
  input  wire logic                      S_AXI_AWVALID_I,
  output logic                           S_AXI_AWREADY_O,
  input  wire logic [31:0]               S_AXI_WDATA_I,
  input  wire logic [3:0]                S_AXI_WSTRB_I,
  input  wire logic                      S_AXI_WVALID_I,
  output logic                           S_AXI_WREADY_O,
  output logic [1:0]                     S_AXI_BRESP_O,
  output logic                           S_AXI_BVALID_O,
  input  wire logic                      S_AXI_BREADY_I,
  input  wire logic [3:0]                S_AXI_ARADDR_I,
  input  wire logic                      S_AXI_ARVALID_I,
  output logic                           S_AXI_ARREADY_O,
  output logic [31:0]                    S_AXI_RDATA_O,
  output logic [1:0]                     S_AXI_RRESP_O,
  output logic                           S_AXI_RVALID_O,
  input  wire logic                      S_AXI_RREADY_I,
  input  wire logic                      STOP_MODE_I,
  input  wire logic                      WAIT_MODE_I,
  input  wire logic [7:0]                ANALOG_RESULT_I,
  output adc_seq_pkg::analog_ctl_t       ANALOG_CTL_O,
  output logic                           CONV_IRQ_O,
  output logic                           WAKEUP_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state

  logic                      irq_en_r;
  logic                      cont_r;
  logic [4:0]                ch_r;
  logic [2:0]                div_r;
  logic                      done_r;
  logic                      irq_r;
  logic [7:0]                result_r;
  adc_seq_pkg::conv_state_t  state_r;
  logic [4:0]                bit_cnt_r;
  logic [3:0]                pre_cnt_r;
  logic                      start_pend_r;
  logic                      stop_s1_r;
  logic                      stop_s2_r;
  logic                      wait_s1_r;
  logic                      wait_s2_r;
  logic                      stop_seen_r;
  logic                      resume_r;

  logic                      aw_held_r;
  logic [3:0]                aw_addr_r;
  logic                      w_held_r;
  logic [31:0]               w_data_r;
  logic [3:0]                w_strb_r;
  logic                      bvalid_r;
  logic [1:0]                bresp_r;
  logic                      rvalid_r;
  logic [1:0]                rresp_r;
  logic [31:0]               rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire aw_take   = CLK_EN_I && S_AXI_AWVALID_I && !aw_held_r && !bvalid_r;
  wire w_take    = CLK_EN_I && S_AXI_WVALID_I && !w_held_r && !bvalid_r;
  wire ar_take   = CLK_EN_I && S_AXI_ARVALID_I && !rvalid_r;
  wire aw_have   = aw_held_r || aw_take;
  wire w_have    = w_held_r || w_take;
  wire wr_fire   = aw_have && w_have && !bvalid_r && CLK_EN_I;
  wire [3:0] wr_addr = aw_held_r ? aw_addr_r : S_AXI_AWADDR_I;
  wire [31:0] wr_data = w_held_r ? w_data_r : S_AXI_WDATA_I;
  wire [3:0] wr_strb = w_held_r ? w_strb_r : S_AXI_WSTRB_I;
  wire wr_ctl    = wr_fire && wr_addr == adc_seq_pkg::ADDR_STATUS_CONTROL && wr_strb[0];
  wire wr_clk    = wr_fire && wr_addr == adc_seq_pkg::ADDR_CLOCK_SELECT && wr_strb[0];
  wire wr_ok     = wr_addr == adc_seq_pkg::ADDR_STATUS_CONTROL
                || wr_addr == adc_seq_pkg::ADDR_CLOCK_SELECT
                || wr_addr == adc_seq_pkg::ADDR_RESULT;
  wire rd_ok     = S_AXI_ARADDR_I == adc_seq_pkg::ADDR_STATUS_CONTROL
                || S_AXI_ARADDR_I == adc_seq_pkg::ADDR_RESULT
                || S_AXI_ARADDR_I == adc_seq_pkg::ADDR_CLOCK_SELECT;
  wire rd_result = ar_take && S_AXI_ARADDR_I == adc_seq_pkg::ADDR_RESULT;

  // Flag reads zero while requests are enabled
  wire [7:0] ctl_view = {done_r & ~irq_en_r, irq_en_r, cont_r, ch_r};
  wire [7:0] clk_view = {div_r, 5'h00};
  wire [7:0] rd_byte  = (S_AXI_ARADDR_I == adc_seq_pkg::ADDR_STATUS_CONTROL) ? ctl_view :
                        (S_AXI_ARADDR_I == adc_seq_pkg::ADDR_RESULT) ? result_r :
                        (S_AXI_ARADDR_I == adc_seq_pkg::ADDR_CLOCK_SELECT) ? clk_view :
                        8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Converter timing

  wire       powered   = ch_r != adc_seq_pkg::CH_POWER_OFF;
  wire       stopped   = stop_s2_r;
  wire [3:0] div_limit = div_r[2] ? 4'hF :
                         div_r == 3'h3 ? 4'h7 :
                         div_r == 3'h2 ? 4'h3 :
                         div_r == 3'h1 ? 4'h1 : 4'h0;
  wire       conv_tick = pre_cnt_r == div_limit;
  wire       running   = state_r == adc_seq_pkg::CONV_RUN;
  wire       last_tick = running && conv_tick && bit_cnt_r == 5'(CONV_LEN - 1);
  // A control write or stop in the completing cycle discards that result
  wire       complete  = last_tick && !wr_ctl && !stopped;
  wire       stop_exit = stop_seen_r && !stopped;

  wire [3:0] pin_sel;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      assign pin_sel[gi] = powered && ch_r == 5'(gi);
    end
  endgenerate

  assign ANALOG_CTL_O = '{power_on:     powered && !stopped,
                          sample:       running,
                          channel:      ch_r,
                          pin_override: pin_sel};

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for mode levels
  // Mode levels come from another domain, so two flops before use

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      stop_s1_r <= 1'b0;
      stop_s2_r <= 1'b0;
      wait_s1_r <= 1'b0;
      wait_s2_r <= 1'b0;
    end else if (CLK_EN_I) begin
      stop_s1_r <= STOP_MODE_I;
      stop_s2_r <= stop_s1_r;
      wait_s1_r <= WAIT_MODE_I;
      wait_s2_r <= wait_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      irq_en_r <= 1'b0;
      cont_r   <= 1'b0;
      ch_r     <= adc_seq_pkg::CH_RESET;
      div_r    <= adc_seq_pkg::CLK_DIV_RESET;
    end else if (wr_ctl) begin
      irq_en_r <= wr_data[adc_seq_pkg::STAT_IRQEN_BIT];
      cont_r   <= wr_data[adc_seq_pkg::STAT_CONT_BIT];
      ch_r     <= wr_data[adc_seq_pkg::STAT_CH_LSB +: adc_seq_pkg::CH_W];
    end else if (wr_clk) begin
      div_r    <= wr_data[adc_seq_pkg::CLK_DIV_LSB +: adc_seq_pkg::CLK_DIV_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      state_r      <= adc_seq_pkg::CONV_IDLE;
      bit_cnt_r    <= 5'h00;
      pre_cnt_r    <= 4'h0;
      start_pend_r <= 1'b0;
    end else if (CLK_EN_I) begin
      // The prescaler runs free, so a new run waits for its next tick
      pre_cnt_r <= conv_tick ? 4'h0 : pre_cnt_r + 4'h1;
      if (wr_ctl) begin
        start_pend_r <= 1'b1;
        state_r      <= adc_seq_pkg::CONV_IDLE;
        bit_cnt_r    <= 5'h00;
      end else if (stopped || !powered) begin
        state_r      <= adc_seq_pkg::CONV_IDLE;
        bit_cnt_r    <= 5'h00;
      end else begin
        case (state_r)
          adc_seq_pkg::CONV_IDLE: begin
            if (start_pend_r && conv_tick) begin
              state_r      <= adc_seq_pkg::CONV_RUN;
              start_pend_r <= 1'b0;
              bit_cnt_r    <= 5'h00;
            end else if (stop_exit && resume_r) begin
              start_pend_r <= 1'b1;
            end
          end
          adc_seq_pkg::CONV_RUN: begin
            if (conv_tick) begin
              if (last_tick) begin
                bit_cnt_r <= 5'h00;
                if (!cont_r) begin
                  state_r <= adc_seq_pkg::CONV_IDLE;
                end
              end else begin
                bit_cnt_r <= bit_cnt_r + 5'h01;
              end
            end
          end
          default: state_r <= adc_seq_pkg::CONV_IDLE;
        endcase
      end
    end
  end

  // A run cut short by stop starts over on the first tick after stop ends
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      stop_seen_r <= 1'b0;
      resume_r    <= 1'b0;
    end else if (CLK_EN_I) begin
      stop_seen_r <= stopped;
      if (wr_ctl || stop_exit) begin
        resume_r <= 1'b0;
      end else if (stopped && running) begin
        resume_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result, flag and request

  // A completion wins over a result read in the same cycle; a control write discards the completion
  wire done_set = complete && !irq_en_r;
  wire done_clr = rd_result || irq_en_r;
  wire irq_set  = complete && irq_en_r;
  wire irq_clr  = rd_result || wr_ctl;

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      result_r <= 8'h00;
      done_r   <= 1'b0;
      irq_r    <= 1'b0;
    end else if (CLK_EN_I) begin
      if (complete) begin
        result_r <= ANALOG_RESULT_I;
      end
      if (done_set) begin
        done_r <= 1'b1;
      end else if (done_clr) begin
        done_r <= 1'b0;
      end
      if (irq_set) begin
        irq_r <= 1'b1;
      end else if (irq_clr) begin
        irq_r <= 1'b0;
      end
    end
  end

  assign CONV_IRQ_O = irq_r && irq_en_r;
  assign WAKEUP_O   = CONV_IRQ_O && wait_s2_r;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_held_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= adc_seq_pkg::RESP_OKAY;
      rvalid_r  <= 1'b0;
      rresp_r   <= adc_seq_pkg::RESP_OKAY;
      rdata_r   <= 32'h0000_0000;
    end else if (CLK_EN_I) begin
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_ok ? adc_seq_pkg::RESP_OKAY : adc_seq_pkg::RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_held_r <= 1'b1;
          aw_addr_r <= S_AXI_AWADDR_I;
        end
        if (w_take) begin
          w_held_r <= 1'b1;
          w_data_r <= S_AXI_WDATA_I;
          w_strb_r <= S_AXI_WSTRB_I;
        end
        if (bvalid_r && S_AXI_BREADY_I) begin
          bvalid_r <= 1'b0;
        end
      end
      // Unmapped addresses answer with an error and read as zero
      if (ar_take) begin
        rvalid_r <= 1'b1;
        rresp_r  <= rd_ok ? adc_seq_pkg::RESP_OKAY : adc_seq_pkg::RESP_SLVERR;
        rdata_r  <= {24'h00_0000, rd_byte};
      end else if (rvalid_r && S_AXI_RREADY_I) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // Readys fall with the clock enable, so nothing is taken while frozen
  assign S_AXI_AWREADY_O = CLK_EN_I && !aw_held_r && !bvalid_r;
  assign S_AXI_WREADY_O  = CLK_EN_I && !w_held_r && !bvalid_r;
  assign S_AXI_BVALID_O  = bvalid_r;
  assign S_AXI_BRESP_O   = bresp_r;
  assign S_AXI_ARREADY_O = CLK_EN_I && !rvalid_r;
  assign S_AXI_RVALID_O  = rvalid_r;
  assign S_AXI_RRESP_O   = rresp_r;
  assign S_AXI_RDATA_O   = rdata_r;

endmodule

// file: src/adc_seq_pkg.sv
/*
  Package for the converter sequencing block: register map, field layout,
  reset values, channel codes, bus response codes and conversion length.
  Assumes a 32-bit AXI4-Lite register bus, one aligned word per register.
*/
package adc_seq_pkg;

  localparam logic [3:0] ADDR_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_RESULT         = 4'h4;
  localparam logic [3:0] ADDR_CLOCK_SELECT   = 4'h8;

  // Status and control, and clock select field positions
  localparam int STAT_DONE_BIT  = 7;
  localparam int STAT_IRQEN_BIT = 6;
  localparam int STAT_CONT_BIT  = 5;
  localparam int STAT_CH_LSB    = 0;
  localparam int CH_W           = 5;
  localparam int CLK_DIV_LSB    = 5;
  localparam int CLK_DIV_W      = 3;

  localparam logic [4:0] CH_RESET     = 5'h1F;
  localparam logic [4:0] CH_POWER_OFF = 5'h1F;
  localparam logic [4:0] CH_HIGH_REF  = 5'h1D;
  localparam logic [4:0] CH_LOW_REF   = 5'h1E;
  localparam logic [4:0] CH_RESERVED  = 5'h1B;
  localparam logic [4:0] CH_LAST_PIN  = 5'h03;
  localparam logic [2:0] CLK_DIV_RESET = 3'h0;

  localparam int CONV_CYCLES = 16;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Analog front-end handshake toward the converter core
  typedef struct packed {
    logic       power_on;
    logic       sample;
    logic [4:0] channel;
    logic [3:0] pin_override;
  } analog_ctl_t;

  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_RUN
  } conv_state_t;

endpackage

// file: verif/adc_mux_model.sv
/*
  Analog multiplexer and converter core model: a fixed level per pin.
  Assumes the design's ANALOG_CTL_O drives ctl_i.
*/
module adc_mux_model (
  input  wire logic                     clk_i,
  input  wire adc_seq_pkg::analog_ctl_t ctl_i,
  output logic [7:0]                    result_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] level;
  assign level = ctl_i.channel == 5'h1D ? 8'hFF
               : ctl_i.channel == 5'h1E ? 8'h00
               : 8'h3C + 8'h21 * {3'h0, ctl_i.channel};
  // Unpowered core gives no settled value
  always @(posedge clk_i)
    if (ctl_i.power_on) result_o <= level;
    else result_o <= ~result_o;
endmodule

// file: verif/adc_seq_ctrl_properties.sv
/*
  Checker for adc_seq_ctrl: request, flag, routing and bus relations.
  Assumes binding to adc_seq_ctrl and writes that offer AW and W together.
*/
module adc_seq_ctrl_properties #(
  parameter int CONV_LEN = adc_seq_pkg::CONV_CYCLES
) (
  input wire logic                     CORE_CLK_I,
  input wire logic                     RST_I,
  input wire logic [3:0]               S_AXI_AWADDR_I,
  input wire logic                     S_AXI_AWVALID_I,
  input wire logic                     S_AXI_AWREADY_O,
  input wire logic [3:0]               S_AXI_WSTRB_I,
  input wire logic                     S_AXI_WVALID_I,
  input wire logic                     S_AXI_WREADY_O,
  input wire logic [3:0]               S_AXI_ARADDR_I,
  input wire logic                     S_AXI_ARVALID_I,
  input wire logic                     S_AXI_ARREADY_O,
  input wire logic [31:0]              S_AXI_RDATA_O,
  input wire logic                     S_AXI_RVALID_O,
  input wire adc_seq_pkg::analog_ctl_t ANALOG_CTL_O,
  input wire logic                     CONV_IRQ_O,
  input wire logic                     WAKEUP_O
);
  logic rd_stat_r;
  always_ff @(posedge CORE_CLK_I)
    if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
      rd_stat_r <= S_AXI_ARADDR_I == adc_seq_pkg::ADDR_STATUS_CONTROL;
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  irq_reset_a: assert property (
    $fell(RST_I) |-> !CONV_IRQ_O && ANALOG_CTL_O.channel == 5'h1F) else $error("reset state");
  power_off_a: assert property (
    ANALOG_CTL_O.channel == adc_seq_pkg::CH_POWER_OFF
    |-> !ANALOG_CTL_O.power_on && !ANALOG_CTL_O.sample) else $error("converter not off");
  pin_route_a: assert property (
    ANALOG_CTL_O.pin_override == ((ANALOG_CTL_O.channel <= 5'h03)
    ? 4'(4'h1 << ANALOG_CTL_O.channel) : 4'h0)) else $error("pin override wrong");
  wake_irq_a: assert property (WAKEUP_O |-> CONV_IRQ_O) else $error("wake without request");
  read_clear_a: assert property (
    CONV_IRQ_O && S_AXI_ARVALID_I && S_AXI_ARREADY_O && !ANALOG_CTL_O.sample
    && S_AXI_ARADDR_I == adc_seq_pkg::ADDR_RESULT |=> !CONV_IRQ_O) else $error("read no clear");
  write_clear_a: assert property (
    S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O && S_AXI_WSTRB_I[0]
    && S_AXI_AWADDR_I == adc_seq_pkg::ADDR_STATUS_CONTROL |=> !CONV_IRQ_O)
    else $error("write no clear");
  irq_level_a: assert property (
    CONV_IRQ_O && !S_AXI_ARVALID_I && !S_AXI_WVALID_I |=> CONV_IRQ_O) else $error("irq dropped");
  done_masked_a: assert property (
    S_AXI_RVALID_O && rd_stat_r && S_AXI_RDATA_O[6] |-> !S_AXI_RDATA_O[7])
    else $error("flag set while enabled");
  rdata_upper_a: assert property (
    S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:8] == 24'h00_0000) else $error("upper bits set");
endmodule

bind adc_seq_ctrl adc_seq_ctrl_properties #(.CONV_LEN(CONV_LEN)) adc_seq_ctrl_properties_i (.*);

// file: verif/tb_top.sv
/*
  Self-checking bench for adc_seq_ctrl with an AXI4-Lite master.
  Assumes CONV_LEN shortened to 4 and the package register map.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int L = 4;
  localparam logic [3:0] SC = adc_seq_pkg::ADDR_STATUS_CONTROL;
  localparam logic [3:0] RS = adc_seq_pkg::ADDR_RESULT;
  localparam logic [3:0] CS = adc_seq_pkg::ADDR_CLOCK_SELECT;
  localparam logic [1:0] OK = adc_seq_pkg::RESP_OKAY;
  localparam logic [1:0] ER = adc_seq_pkg::RESP_SLVERR;
  logic        clk = 0, rst = 1, en = 1, stop = 0, wt = 0;
  logic        awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [3:0]  awa = 0, ara = 0, wst = 4'hF;
  logic [31:0] wd = 0, rd;
  logic        awr, wrd, bv, arr, rv, irq, wake;
  logic [1:0]  br, rr;
  logic [7:0]  ares;
  adc_seq_pkg::analog_ctl_t actl;
  int          fail_count = 0, n_compared = 0, scnt = 0;

  adc_seq_ctrl #(.CONV_LEN(L)) adc_seq_ctrl_i (
    .CORE_CLK_I(clk), .RST_I(rst), .CLK_EN_I(en), .S_AXI_AWADDR_I(awa),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(wst),
    .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrd), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv),
    .S_AXI_BREADY_I(bry), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
    .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv),
    .S_AXI_RREADY_I(rry), .STOP_MODE_I(stop), .WAIT_MODE_I(wt), .ANALOG_RESULT_I(ares),
    .ANALOG_CTL_O(actl), .CONV_IRQ_O(irq), .WAKEUP_O(wake));
  adc_mux_model adc_mux_model_i (.clk_i(clk), .ctl_i(actl), .result_o(ares));

  initial forever #5 clk = ~clk;
  always @(posedge clk) if (actl.sample) scnt <= scnt + 1;

  function automatic logic [7:0] exp_res(input logic [4:0] ch);
    return ch == 5'h1D ? 8'hFF : ch == 5'h1E ? 8'h00 : 8'h3C + 8'h21 * {3'h0, ch};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (fail_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bry <= 1;
    do begin
      @(posedge clk);
      n++;
      if (awv && awr) awv <= 0;
      if (wv && wrd) wv <= 0;
    end while (!bv && n < 50);
    bry <= 0;
    chk(32'(br), 32'(er));
    if (n >= 50) fail_count++;
  endtask
  task automatic rdx(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    ara <= a;
    arv <= 1;
    rry <= 1;
    do begin
      @(posedge clk);
      n++;
      if (arv && arr) arv <= 0;
    end while (!rv && n < 50);
    rry <= 0;
    chk(rd, ed);
    chk(32'(rr), 32'(er));
    if (n >= 50) fail_count++;
  endtask
  task automatic conv(input logic [2:0] p, input logic [4:0] ch, input logic ie);
    int d, s0;
    d = p[2] ? 16 : 1 << p;
    wr(CS, {24'h00_0000, p, 5'h00}, OK);
    wr(SC, {24'h00_0000, 1'b0, ie, 1'b0, ch}, OK);
    s0 = scnt;
    repeat ((L + 3) * d + 6) @(posedge clk);
    chk(32'(scnt - s0 > (L - 1) * d && scnt - s0 <= (L + 1) * d), 32'h0000_0001);
    chk({30'h0, irq, wake}, {30'h0, ie, ie & wt});
    rdx(SC, {24'h00_0000, ~ie, ie, 1'b0, ch}, OK);
    rdx(RS, {24'h00_0000, exp_res(ch)}, OK);
    chk(32'(irq), 32'h0000_0000);
    rdx(SC, {24'h00_0000, 1'b0, ie, 1'b0, ch}, OK);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    stop_test;
  end
  initial begin
    void'($urandom(32'h0000_DB65));
    repeat (10) @(posedge clk);
    rst <= 0;
    rdx(SC, 32'h0000_001F, OK);
    rdx(RS, 32'h0000_0000, OK);
    rdx(CS, 32'h0000_0000, OK);
    rdx(4'hC, 32'h0000_0000, ER);
    wr(4'hC, 32'h0000_0001, ER);
    wr(RS, 32'h0000_00FF, OK);
    rdx(RS, 32'h0000_0000, OK);
    wr(SC, 32'h0000_0000, OK);
    repeat (2 * L + 8) @(posedge clk);
    for (int i = 0; i < 8; i++) conv(3'(i), 5'($urandom % 4), i[0]);
    conv(3'h0, 5'h1D, 1'b0);
    conv(3'h1, 5'h1E, 1'b1);
    wt <= 1;
    conv(3'h2, 5'h03, 1'b1);
    wt <= 0;
    wr(SC, 32'h0000_0043, OK);
    repeat (40) @(posedge clk);
    chk(32'(irq), 32'h0000_0001);
    wr(SC, 32'h0000_001F, OK);
    chk(32'(irq), 32'h0000_0000);
    wr(CS, 32'h0000_0000, OK);
    wr(SC, 32'h0000_0022, OK);
    repeat (2 * L + 8) @(posedge clk);
    rdx(RS, {24'h00_0000, exp_res(5'h02)}, OK);
    repeat (L + 4) @(posedge clk);
    rdx(SC, 32'h0000_00A2, OK);
    chk(32'(actl.sample), 32'h0000_0001);
    wr(SC, 32'h0000_001F, OK);
    wt <= 1;
    repeat (L + 4) @(posedge clk);
    chk({29'h0, actl.sample, actl.power_on, wake}, 32'h0000_0000);
    wt <= 0;
    rdx(RS, {24'h00_0000, exp_res(5'h02)}, OK);
    wr(CS, 32'h0000_0080, OK);
    wr(SC, 32'h0000_0001, OK);
    repeat (30) @(posedge clk);
    stop <= 1;
    repeat (5) @(posedge clk);
    chk({30'h0, actl.sample, actl.power_on}, 32'h0000_0000);
    repeat (100) @(posedge clk);
    stop <= 0;
    repeat (5) @(posedge clk);
    rdx(SC, 32'h0000_0001, OK);
    repeat (L * 16 + 32) @(posedge clk);
    rdx(SC, 32'h0000_0081, OK);
    conv(3'h4, 5'h01, 1'b0);
    stop_test;
  end
endmodule
